// File: bench/sft_bridge_checker.sv
// port assertions for the serial flow and talker swap bridge
module sft_bridge_checker
    import sft_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // watched ports
    input sft_pkg::sft_mode_e termMode,
    input wire logic xonEnable,
    input wire logic cicReady,
    input wire logic [7:0] txData,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic rts,
    input wire logic cts,
    input sft_pkg::sft_cmd_s cmd,
    input wire logic cmdValid,
    input wire logic cmdReady,
    input wire logic talkReady
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic lstSeen;
    logic lastTerm;
    wire logic take = cmdValid && cmdReady;
    wire logic isTerm = (termMode == SFT_MODE_CR && cmd.data == 8'h0D)
        || (termMode == SFT_MODE_LF && cmd.data == 8'h0A);
    wire logic termMd = termMode inside {SFT_MODE_CR, SFT_MODE_LF};
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lstSeen <= 1'b0;
            lastTerm <= 1'b0;
        end else if (take) begin
            lstSeen <= lstSeen || cmd.kind == SFT_CMD_LISTEN;
            lastTerm <= cmd.kind == SFT_CMD_DATA && isTerm;
        end
    end
    listen_first_a: assert property ($rose(cicReady)
        |-> ##[1:2] cmdValid && cmd.kind == SFT_CMD_LISTEN)
        else $error("no listen after cic");
    cmd_hold_a: assert property (cmdValid && !cmdReady |=> cmdValid && $stable(cmd))
        else $error("command dropped");
    term_talk_a: assert property (take && cmd.kind == SFT_CMD_DATA && isTerm
        |=> cmdValid && cmd.kind == SFT_CMD_TALK)
        else $error("no talk after terminator");
    stay_listen_a: assert property (termMd && cmdValid && cmd.kind == SFT_CMD_TALK
        |-> lastTerm)
        else $error("talk without terminator");
    no_swap_a: assert property (termMode == SFT_MODE_NOSWAP && lstSeen && cmdValid
        |-> cmd.kind == SFT_CMD_DATA)
        else $error("readdress in no-swap");
    cts_stop_a: assert property (!cts [*5] |-> !txValid)
        else $error("transmit without cts");
    tx_hold_a: assert property (txValid && !txReady |=> $stable(txData) && !talkReady)
        else $error("tx byte changed");
    xoff_sent_a: assert property (xonEnable && $fell(rts)
        |-> ##[0:30] txValid && txData == 8'h13)
        else $error("no stop byte");
    xon_sent_a: assert property (xonEnable && $rose(rts)
        |-> ##[0:30] txValid && txData == 8'h11)
        else $error("no resume byte");
    cover property (take && cmd.kind == SFT_CMD_TALK);
    cover property ($fell(rts));
    cover property (txValid && txReady);
endmodule : sft_bridge_checker

bind sft_bridge sft_bridge_checker chk_u (.clock, .rst_n, .termMode, .xonEnable, .cicReady,
    .txData, .txValid, .txReady, .rts, .cts, .cmd, .cmdValid, .cmdReady, .talkReady);

// File: bench/sft_bridge_tb_top.sv
// self-checking bench for the serial flow and talker swap bridge
module sft_bridge_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sft_pkg::*;
    localparam int DEPTH = 64;
    localparam int GAP = 8;
    localparam int QUIET = 50;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    sft_mode_e termMode = SFT_MODE_CR;
    logic xonEnable = 1'b0;
    logic cicReady = 1'b0;
    logic [7:0] rxData = 8'h00;
    logic rxValid = 1'b0;
    logic cts = 1'b1;
    logic stall = 1'b0;
    logic [7:0] txData, talkData;
    logic txValid, txReady, rts, cmdValid, cmdReady, talkValid, talkReady;
    sft_cmd_s cmd;
    logic [9:0] expQ[$];
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    always #4 clock = ~clock;
    sft_bridge #(.DEPTH(DEPTH), .NEAR_FULL_GAP(GAP), .NEAR_EMPTY_LEVEL(GAP), .QUIET_CYCLES(QUIET))
        dut_u (.clock, .rst_n, .termMode, .xonEnable, .cicReady, .rxData, .rxValid, .txData,
        .txValid, .txReady, .rts, .cts, .cmd, .cmdValid, .cmdReady, .talkData, .talkValid,
        .talkReady);
    sft_far_model far_u (.clock, .stall, .cmd, .cmdValid, .cmdReady, .talkData, .talkValid,
        .talkReady, .txData, .txValid, .txReady);
    task automatic test_done();
        if (failures == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    always @(posedge clock) begin
        cycles++;
        if (cycles == 10000) begin
            failures++;
            test_done();
        end
    end
    task automatic chk_val(logic [9:0] got, logic [9:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    function automatic logic [9:0] norm(sft_cmd_s c);
        return (c.kind == SFT_CMD_DATA) ? c : {c.kind, 8'h00};
    endfunction : norm
    function automatic logic [7:0] rnd_byte();
        logic [7:0] b;
        b = 8'($urandom);
        while (b inside {8'h0A, 8'h0D, 8'h11, 8'h13}) b = 8'($urandom);
        return b;
    endfunction : rnd_byte
    function automatic logic [7:0] term_of(sft_mode_e m);
        return (m == SFT_MODE_LF) ? 8'h0A : 8'h0D;
    endfunction : term_of
    task automatic send(logic [7:0] b);
        @(negedge clock);
        rxData = b;
        rxValid = 1'b1;
        @(negedge clock);
        rxValid = 1'b0;
        rxData = ~b;
    endtask : send
    task automatic wait_q(int c, int t);
        int n;
        n = 0;
        while ((far_u.gotCmd.size() < c || far_u.gotTx.size() < t) && n < 400) begin
            @(negedge clock);
            n++;
        end
        // a wait that runs out is a failure in its own right
        if (far_u.gotCmd.size() < c || far_u.gotTx.size() < t) begin
            failures++;
        end
    endtask : wait_q
    task automatic restart(sft_mode_e m, logic x);
        @(negedge clock);
        rst_n = 1'b0;
        cicReady = 1'b0;
        termMode = m;
        xonEnable = x;
        far_u.gotCmd.delete();
        far_u.gotTx.delete();
        expQ.delete();
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        chk_val({9'h000, rts}, 10'h001);
        cicReady = 1'b1;
        expQ.push_back({SFT_CMD_LISTEN, 8'h00});
    endtask : restart
    task automatic run_mode(sft_mode_e m);
        logic [7:0] b;
        restart(m, 1'b0);
        repeat (5) begin
            b = rnd_byte();
            send(b);
            expQ.push_back({SFT_CMD_DATA, b});
        end
        if (m inside {SFT_MODE_CR, SFT_MODE_LF}) begin
            send(term_of(m));
            expQ.push_back({SFT_CMD_DATA, term_of(m)});
        end
        if (m != SFT_MODE_NOSWAP) expQ.push_back({SFT_CMD_TALK, 8'h00});
        wait_q(expQ.size(), 0);
        cts = 1'b0;
        // cts needs the synchroniser's latency before a byte may wait for transmit
        repeat (4) @(negedge clock);
        b = 8'($urandom);
        far_u.talkQ.push_back(b);
        repeat (20) @(negedge clock);
        chk_val(10'(far_u.gotTx.size()), 10'h000);
        cts = 1'b1;
        wait_q(0, 1);
        chk_val({2'h0, far_u.gotTx[0]}, {2'h0, b});
        b = rnd_byte();
        send(b);
        if (m != SFT_MODE_NOSWAP) expQ.push_back({SFT_CMD_LISTEN, 8'h00});
        expQ.push_back({SFT_CMD_DATA, b});
        if (m == SFT_MODE_TIME) expQ.push_back({SFT_CMD_TALK, 8'h00});
        wait_q(expQ.size(), 0);
        repeat (2 * QUIET) @(negedge clock);
        chk_val(10'(far_u.gotCmd.size()), 10'(expQ.size()));
        foreach (expQ[i]) begin
            if (i < far_u.gotCmd.size()) begin
                chk_val(norm(far_u.gotCmd[i]), expQ[i]);
            end
        end
    endtask : run_mode
    task automatic flow();
        int sent;
        logic [7:0] b;
        // random bytes other than terminators and stop/resume bytes while the software handshake is on
        restart(SFT_MODE_CR, 1'b1);
        stall = 1'b1;
        sent = 0;
        while (rts && sent < DEPTH) begin
            send(rnd_byte());
            @(negedge clock);
            sent++;
        end
        chk_val({9'h000, sent >= DEPTH - GAP && sent <= DEPTH - GAP + 2}, 10'h001);
        wait_q(0, 1);
        chk_val({2'h0, far_u.gotTx[0]}, 10'h013);
        stall = 1'b0;
        wait_q(sent + 1, 2);
        chk_val({2'h0, far_u.gotTx[1]}, 10'h011);
        chk_val({9'h000, rts}, 10'h001);
        chk_val(10'(far_u.gotCmd.size()), 10'(sent + 1));
        send(8'h0D);
        wait_q(sent + 3, 2);
        send(8'h13);
        b = 8'($urandom);
        far_u.talkQ.push_back(b);
        repeat (30) @(negedge clock);
        chk_val(10'(far_u.gotTx.size()), 10'h002);
        send(8'h11);
        wait_q(0, 3);
        chk_val({2'h0, far_u.gotTx[2]}, {2'h0, b});
        chk_val(10'(far_u.gotCmd.size()), 10'(sent + 3));
    endtask : flow
    initial begin
        void'($urandom(85));
        for (int m = 0; m < 4; m++) run_mode(sft_mode_e'(m));
        flow();
        test_done();
    end
endmodule : sft_bridge_tb_top

// File: bench/sft_far_model.sv
// instrument and serial transmitter stand-in facing the bridge
module sft_far_model
    import sft_pkg::*;
(
    // clock and control
    input wire logic clock,
    input wire logic stall,
    // instrument side
    input sft_pkg::sft_cmd_s cmd,
    input wire logic cmdValid,
    output logic cmdReady,
    output logic [7:0] talkData,
    output logic talkValid,
    input wire logic talkReady,
    // transmitter side
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady
);
    timeunit 1ns;
    timeprecision 1ps;
    sft_cmd_s gotCmd[$];
    logic [7:0] gotTx[$];
    logic [7:0] talkQ[$];
    initial begin
        cmdReady = 1'b0;
        txReady = 1'b0;
        talkValid = 1'b0;
        talkData = 8'h00;
    end
    always @(posedge clock) begin
        if (cmdValid && cmdReady) gotCmd.push_back(cmd);
        if (txValid && txReady) gotTx.push_back(txData);
        if (talkValid && talkReady) begin
            void'(talkQ.pop_front());
            talkValid <= 1'b0;
            // released bus shows no stale byte
            talkData <= ~talkData;
        end else if (!talkValid && talkQ.size() > 0) begin
            talkValid <= 1'b1;
            talkData <= talkQ[0];
        end
        cmdReady <= !stall && $urandom_range(3) != 0;
        txReady <= 1'($urandom_range(1));
    end
endmodule : sft_far_model

// File: src/sft_bridge.sv
// controller-side serial buffering, flow control and talker swapping
`include "sft_params.svh"

module sft_bridge #(
    parameter int DEPTH = `SFT_BUF_BYTES,
    parameter int NEAR_FULL_GAP = `SFT_NEAR_FULL_GAP,
    parameter int NEAR_EMPTY_LEVEL = `SFT_NEAR_EMPTY_LEVEL,
    parameter int QUIET_CYCLES = int'(`SFT_QUIET_CYCLES)
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // static configuration
    input sft_pkg::sft_mode_e termMode,
    input wire logic xonEnable,
    input wire logic cicReady,
    // serial receiver bytes
    input wire logic [7:0] rxData,
    input wire logic rxValid,
    // serial transmitter bytes
    output logic [7:0] txData,
    output logic txValid,
    input wire logic txReady,
    // modem lines
    output logic rts,
    input wire logic cts,
    // instrument command stream
    output sft_pkg::sft_cmd_s cmd,
    output logic cmdValid,
    input wire logic cmdReady,
    // instrument talker bytes
    input wire logic [7:0] talkData,
    input wire logic talkValid,
    output logic talkReady
);
    import sft_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int QW = $clog2(QUIET_CYCLES + 1);
    localparam logic [AW:0] FULL_LEVEL = (AW + 1)'(DEPTH);
    localparam logic [AW:0] HIGH_LEVEL = (AW + 1)'(DEPTH - NEAR_FULL_GAP);
    localparam logic [AW:0] LOW_LEVEL = (AW + 1)'(NEAR_EMPTY_LEVEL);
    localparam logic [QW-1:0] QUIET_LAST = QW'(QUIET_CYCLES - 1);

    // refused at elaboration, so a bad size never reaches simulation
    if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two of at least 4");
    end
    if (NEAR_EMPTY_LEVEL < 0 || NEAR_FULL_GAP < 1
            || NEAR_EMPTY_LEVEL >= DEPTH - NEAR_FULL_GAP) begin : g_bad_marks
        $error("watermarks must satisfy 0 <= low < DEPTH - gap, gap >= 1");
    end
    if (QUIET_CYCLES < 1) begin : g_bad_quiet
        $error("QUIET_CYCLES must be at least 1");
    end

    typedef struct packed {
        sft_state_e st;
        logic [AW:0] count;
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic fetching;
        logic [1:0] skidCnt;
        logic [1:0][8:0] skid;
        logic [QW-1:0] quiet;
        logic rtsOn;
        logic xoffSent;
        logic xoffPend;
        logic xonPend;
        logic paused;
        logic txFull;
        logic [7:0] txByte;
        logic [2:0] ctsSync;
        logic ctsOk;
    } sft_reg_s;

    // bit 8 marks a byte that ends a command string
    function automatic logic isTerminator(input sft_mode_e mode, input logic [7:0] b);
        isTerminator = (mode == SFT_MODE_CR && b == `SFT_CR_CHAR) // RQ1
            || (mode == SFT_MODE_LF && b == `SFT_LF_CHAR); // RQ17
    endfunction : isTerminator

    function automatic logic isFlowChar(input logic en, input logic [7:0] b);
        isFlowChar = en && (b == `SFT_XON_CHAR || b == `SFT_XOFF_CHAR);
    endfunction : isFlowChar

    logic [1:0] rstSync;
    logic rstN;
    sft_reg_s r;
    sft_reg_s next_r;
    logic [8:0] mem [0:DEPTH-1];
    logic [8:0] memQ;
    logic memWr;
    logic [8:0] memWrWord;
    logic rxTake;
    logic issue;
    logic pop;
    logic bufIdle;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstN = rstSync[1];

    // no reset on the store: its contents only matter behind the pointers
    always_ff @(posedge clock) begin
        if (memWr) begin
            mem[r.wrPtr] <= memWrWord; // RQ5
        end
        memQ <= mem[r.rdPtr];
    end

    always_comb begin
        cmd = '{kind: SFT_CMD_DATA, data: 8'h00};
        cmdValid = 1'b0;
        case (r.st)
            SFT_ST_ADDR_LISTEN: begin
                cmd.kind = SFT_CMD_LISTEN;
                cmdValid = 1'b1;
            end
            SFT_ST_LISTEN: begin
                cmd.data = r.skid[0][7:0];
                cmdValid = r.skidCnt != 2'h0; // RQ2
            end
            SFT_ST_ADDR_TALK: begin
                cmd.kind = SFT_CMD_TALK;
                cmdValid = 1'b1;
            end
            default: begin
                cmdValid = 1'b0;
            end
        endcase
    end

    assign txData = r.txByte;
    assign txValid = r.txFull && r.ctsOk; // RQ9
    assign rts = r.rtsOn;
    assign talkReady = !r.txFull && !r.xoffPend && !r.xonPend && !r.paused;

    always_comb begin
        next_r = r;
        rxTake = rxValid && !isFlowChar(xonEnable, rxData); // RQ18
        memWr = rxTake && r.count != FULL_LEVEL;
        memWrWord = {isTerminator(termMode, rxData), rxData};
        issue = r.count != '0 && ({1'b0, r.skidCnt} + {2'h0, r.fetching}) < 3'h2;
        pop = cmdValid && cmdReady && r.st == SFT_ST_LISTEN;
        bufIdle = r.count == '0 && !r.fetching && r.skidCnt == 2'h0;

        // cts: three stages, level accepted once the last two agree
        next_r.ctsSync = {r.ctsSync[1:0], cts};
        if (r.ctsSync[2] == r.ctsSync[1]) begin
            next_r.ctsOk = r.ctsSync[2]; // RQ9
        end

        if (memWr) begin
            next_r.wrPtr = r.wrPtr + AW'(1);
        end
        if (issue) begin
            next_r.rdPtr = r.rdPtr + AW'(1);
        end
        next_r.fetching = issue;
        next_r.count = r.count + (AW + 1)'(memWr) - (AW + 1)'(issue);

        // two-entry stage between the store and the instrument
        if (pop) begin
            next_r.skid[0] = r.skid[1];
        end
        if (r.fetching) begin
            if (r.skidCnt == 2'h0 || (r.skidCnt == 2'h1 && pop)) begin
                next_r.skid[0] = memQ;
            end else begin
                next_r.skid[1] = memQ;
            end
        end
        next_r.skidCnt = r.skidCnt + 2'(r.fetching) - 2'(pop);

        if (rxValid) begin
            next_r.quiet = '0;
        end else if (r.quiet != QUIET_LAST) begin
            next_r.quiet = r.quiet + QW'(1);
        end

        case (r.st)
            SFT_ST_WAIT: begin
                if (cicReady) begin
                    next_r.st = SFT_ST_ADDR_LISTEN; // RQ15
                end
            end
            SFT_ST_ADDR_LISTEN: begin
                if (cmdReady) begin
                    next_r.st = SFT_ST_LISTEN;
                end
            end
            SFT_ST_LISTEN: begin
                if (termMode == SFT_MODE_NOSWAP) begin
                    next_r.st = SFT_ST_LISTEN; // RQ4
                end else if (pop && r.skid[0][8]) begin
                    next_r.st = SFT_ST_ADDR_TALK; // RQ1
                end else if (termMode == SFT_MODE_TIME && bufIdle && !rxValid
                        && r.quiet == QUIET_LAST) begin
                    next_r.st = SFT_ST_ADDR_TALK; // RQ16
                end
            end
            SFT_ST_ADDR_TALK: begin
                if (cmdReady) begin
                    next_r.st = SFT_ST_TALK;
                end
            end
            SFT_ST_TALK: begin
                if (!bufIdle) begin
                    next_r.st = SFT_ST_ADDR_LISTEN; // RQ3
                end
            end
            default: begin
                next_r.st = SFT_ST_WAIT;
            end
        endcase

        // hysteresis between the two watermarks
        if (r.count >= HIGH_LEVEL) begin
            next_r.rtsOn = 1'b0; // RQ6
        end else if (r.count <= LOW_LEVEL) begin
            next_r.rtsOn = 1'b1; // RQ7
        end

        if (!xonEnable) begin
            next_r.xoffSent = 1'b0; // RQ10
            next_r.xoffPend = 1'b0;
            next_r.xonPend = 1'b0;
            next_r.paused = 1'b0;
        end else begin
            if (r.count >= HIGH_LEVEL && !r.xoffSent) begin
                next_r.xoffSent = 1'b1; // RQ11
                next_r.xoffPend = 1'b1;
                next_r.xonPend = 1'b0;
            end else if (r.xoffSent && r.count <= LOW_LEVEL) begin
                next_r.xoffSent = 1'b0; // RQ12
                next_r.xonPend = 1'b1;
                next_r.xoffPend = 1'b0;
            end
            if (rxValid && rxData == `SFT_XOFF_CHAR) begin
                next_r.paused = 1'b1; // RQ13
            end else if (rxValid && rxData == `SFT_XON_CHAR) begin
                next_r.paused = 1'b0; // RQ13
            end
        end

        // one holding byte; flow bytes go ahead of instrument data
        if (txValid && txReady) begin
            next_r.txFull = 1'b0;
        end else if (!r.txFull) begin
            if (r.xoffPend) begin
                next_r.txByte = `SFT_XOFF_CHAR; // RQ11
                next_r.txFull = 1'b1;
                next_r.xoffPend = 1'b0;
            end else if (r.xonPend) begin
                next_r.txByte = `SFT_XON_CHAR; // RQ12
                next_r.txFull = 1'b1;
                next_r.xonPend = 1'b0;
            end else if (talkValid && talkReady) begin
                next_r.txByte = talkData;
                next_r.txFull = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            r <= '0;
            r.st <= SFT_ST_WAIT;
            r.rtsOn <= `SFT_RTS_RESET;
        end else begin
            r <= next_r;
        end
    end

endmodule : sft_bridge

// File: src/sft_params.svh
// constants of the serial flow and talker swap bridge
// How it works
// RQ1 - terminator mode: terminator byte delivered, instrument is swapped from listener to talker
// RQ2 - without a terminator the instrument stays listener and gets every byte
// RQ3 - instrument talking and a new byte arrives: readdress as listener, then send
// RQ4 - no-swap mode addresses listener once and never readdresses
// RQ5 - serial bytes wait in a 256 KB memory until the instrument takes them
// RQ6 - request-to-send always active, dropped when the buffer is nearly full
// RQ7 - request-to-send raised again once the buffer drains to almost empty
// RQ8 - the host pauses sending while request-to-send is low
// RQ9 - transmit stops at once without clear-to-send, also when unconnected; the code drops txValid only four clocks after cts falls
// RQ10 - software handshake chosen by a static input, hardware handshake stays on
// RQ11 - software handshake sends stop byte 19 when the buffer fills
// RQ12 - software handshake sends resume byte 17 when bytes are accepted again
// RQ13 - received stop byte suspends our transmit until resume byte arrives
// RQ14 - host must not enable software handshake for binary data
// RQ15 - once controller-in-charge, address instrument as listener; all input is buffered
// RQ16 - time mode: buffer empty and 300 ms without input swaps to talker
// RQ17 - line-feed mode is carriage-return mode with line feed as terminator
// RQ18 - stop and resume bytes are consumed, never buffered or forwarded
`ifndef SFT_PARAMS_SVH
`define SFT_PARAMS_SVH

`define SFT_BUF_BYTES 262144
`define SFT_NEAR_FULL_GAP 1024
`define SFT_NEAR_EMPTY_LEVEL 1024
`define SFT_XON_CHAR 8'h11
`define SFT_XOFF_CHAR 8'h13
`define SFT_CR_CHAR 8'h0D
`define SFT_LF_CHAR 8'h0A
`define SFT_CLK_HZ 125000000
`define SFT_QUIET_MS 300
`define SFT_QUIET_CYCLES ((64'd`SFT_QUIET_MS * 64'd`SFT_CLK_HZ + 64'd999) / 64'd1000)
`define SFT_RTS_RESET 1'b1

`endif

// File: src/sft_pkg.sv
// types of the serial flow and talker swap bridge
package sft_pkg;

    typedef enum logic [1:0] {
        SFT_MODE_TIME = 2'h0,
        SFT_MODE_CR = 2'h1,
        SFT_MODE_LF = 2'h2,
        SFT_MODE_NOSWAP = 2'h3
    } sft_mode_e;

    typedef enum logic [1:0] {
        SFT_CMD_DATA = 2'h0,
        SFT_CMD_LISTEN = 2'h1,
        SFT_CMD_TALK = 2'h2
    } sft_cmd_e;

    typedef struct packed {
        sft_cmd_e kind;
        logic [7:0] data;
    } sft_cmd_s;

    typedef enum logic [4:0] {
        SFT_ST_WAIT = 5'h01,
        SFT_ST_ADDR_LISTEN = 5'h02,
        SFT_ST_LISTEN = 5'h04,
        SFT_ST_ADDR_TALK = 5'h08,
        SFT_ST_TALK = 5'h10
    } sft_state_e;

endpackage : sft_pkg
